// ---- adc_regs_pkg.sv ----
// Purpose: Shared constants and types for the converter register block
// Assumes: Compiled before every module that imports it
// Notes:   Bit positions refer to the 8-bit command, status and mode bytes
`default_nettype none
package adc_regs_pkg;
  localparam int         DATA_W_DEF     = 16;
  localparam int         LAST_BYTE_BIT  = 7;
  localparam logic [1:0] RS_COMM_STATUS = 2'h0;
  localparam logic [1:0] RS_MODE        = 2'h1;
  localparam logic [1:0] RS_RESERVED    = 2'h2;
  localparam logic [1:0] RS_DATA        = 2'h3;
  localparam logic [1:0] CH_DIFF        = 2'h0;
  localparam logic [1:0] CH_RESERVED    = 2'h1;
  localparam logic [1:0] CH_SHORTED     = 2'h2;
  localparam logic [1:0] CH_SUPPLY      = 2'h3;
  localparam int         CMD_RS_MSB     = 5;
  localparam int         CMD_RS_LSB     = 4;
  localparam int         CMD_RW_BIT     = 3;
  localparam int         CMD_CH_MSB     = 1;
  localparam int         MR_OP_MSB      = 7;
  localparam int         MR_OP_LSB      = 6;
  localparam int         MR_UB_BIT      = 2;
  localparam logic [7:0] MODE_RESET     = 8'h02;
  localparam logic [1:0] OP_POWER_DOWN  = 2'h3;
  localparam logic       RDY_N_RESET    = 1'b1;
  localparam logic       ERR_RESET      = 1'b0;
  localparam logic [1:0] CH_RESET       = CH_DIFF;

  typedef enum logic [1:0] {EV_CMD, EV_MODE, EV_READ_DONE} link_event_kind_t;

  typedef struct packed {
    link_event_kind_t kind;
    logic [1:0]       rs;
    logic [7:0]       value;
  } link_event_t;

  typedef struct packed {
    logic       rdy_n;
    logic       err;
    logic [1:0] zero;
    logic       one;
    logic       variant_flag;
    logic [1:0] input_select;
  } status_t;

  typedef struct packed {
    logic [1:0] operating_select;
    logic [2:0] zero;
    logic       unipolar;
    logic       one;
    logic       zero_lsb;
  } mode_t;

  typedef enum {PH_CMD, PH_WRITE, PH_READ} link_phase_t;
endpackage
`default_nettype wire

// ---- toggle_sync.sv ----
// Purpose: Carries a toggle event from the link clock into the core clock
// Assumes: Toggles are spaced several core cycles apart
// Notes:   Pulse is one core cycle wide, two edges after the toggle
`timescale 1ns/1ns
`default_nettype none
module toggle_sync
  import adc_regs_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic toggle_in,
  output logic      pulse_out
);
  logic meta_r;
  logic sync_r;
  logic seen_r;

  // Only sync_r reads meta_r
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else
    begin
      meta_r <= toggle_in;
      sync_r <= meta_r;
      seen_r <= sync_r;
    end
  end

  assign pulse_out = sync_r ^ seen_r;
endmodule
`default_nettype wire

// ---- result_flags.sv ----
// Purpose: Result-pending and clamp-error flags of the status byte
// Assumes: All event inputs are one-cycle pulses on the core clock
// Notes:   A new result outranks every event that would raise pending
`timescale 1ns/1ns
`default_nettype none
module result_flags
  import adc_regs_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic result_write_in,
  input  wire logic clamp_in,
  input  wire logic data_read_in,
  input  wire logic update_soon_in,
  input  wire logic mode_write_in,
  input  wire logic pd_enter_in,
  input  wire logic start_conv_in,
  output logic      rdy_n_out,
  output logic      err_out
);
  logic rdy_n_nxt;
  logic err_nxt;
  logic raise;

  assign raise = data_read_in | update_soon_in | mode_write_in
               | pd_enter_in;                              // [RULE6] [RULE7]
  // Result never lost to a simultaneous raise
  assign rdy_n_nxt = result_write_in ? 1'b0                // [RULE5]
                   : raise           ? 1'b1                // [RULE20]
                   : rdy_n_out;
  // Error is rewritten together with pending
  assign err_nxt   = result_write_in ? clamp_in            // [RULE9] [RULE10]
                   : start_conv_in   ? 1'b0                // [RULE11]
                   : err_out;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rdy_n_out <= RDY_N_RESET;                            // [RULE15]
      err_out   <= ERR_RESET;
    end
    else
    begin
      rdy_n_out <= rdy_n_nxt;
      err_out   <= err_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- adc_status_mode_regs.sv ----
// Purpose: Status and mode registers behind the converter serial port
// Assumes: Host keeps the rules that bind it; sclk idles high
// Notes:   Serial logic runs on sclk_in, registers on core_clk_in
// Summary of operation
// RULE1: Channel codes: differential, reserved, shorted, supply.
// RULE2: Status is read only; writes ignored.
// RULE3: Host reads status via read command, select zero.
// RULE4: Status shifts out bit 7 first.
// RULE5: New result clears pending flag.
// RULE6: Data read or imminent update sets pending.
// RULE7: Entering power-down sets pending.
// RULE8: Serial-out pin shows pending between transfers.
// RULE9: Error flag updates with pending flag.
// RULE10: Error set when result was clamped.
// RULE11: Conversion-starting write clears error flag.
// RULE12: Status bits 5,4 zero; bit 3 one.
// RULE13: Status bit 2 is fixed variant flag.
// RULE14: Status bits 1,0 give converted channel.
// RULE15: Status resets pending, no error, channel 00.
// RULE16: Mode register is 8 bits, read/write.
// RULE17: Mode select code 01, reset 0x02.
// RULE18: Mode layout fixed; MSB first.
// RULE19: Mode sets coding polarity and power-down.
// RULE20: Mode write resets filter, sets pending.
// RULE21: Command byte: start bit zero, fields decoded.
// RULE22: Select codes address comm/status, mode, data.
// RULE23: Channel change resets filter, restarts conversion.
// RULE24: Host never programs reserved channel code.
`timescale 1ns/1ns
`default_nettype none
module adc_status_mode_regs
  import adc_regs_pkg::*;
#(
  parameter int   DATA_W       = DATA_W_DEF,
  parameter logic VARIANT_FLAG = 1'b0
)
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              sclk_in,
  input  wire logic              cs_n_in,
  input  wire logic              din_in,
  output logic                   dout_out,
  output logic                   dout_oe_n_out,
  input  wire logic              result_valid_in,
  input  wire logic [DATA_W-1:0] result_in,
  input  wire logic              clamp_in,
  input  wire logic              update_soon_in,
  output logic                   filter_reset_out,
  output logic [1:0]             input_select_out,
  output logic [1:0]             operating_select_out,
  output logic                   unipolar_out,
  output logic                   power_down_out
);
  generate
    if (DATA_W < 9 || DATA_W > 24)
    begin : g_bad_width
      $error("DATA_W must lie between 9 and 24");
    end
  endgenerate

  // Link side
  logic              lk_clr;
  link_phase_t       lk_phase_r;
  link_phase_t       lk_phase_nxt;
  logic [4:0]        lk_cnt_r;
  logic [4:0]        lk_cnt_nxt;
  logic [4:0]        lk_last_idx;
  logic [7:0]        lk_sh_r;
  logic [7:0]        lk_byte;
  logic [1:0]        lk_rs_r;
  logic              lk_hold;
  logic              lk_last;
  logic              lk_cmd_done;
  link_event_t       lk_ev_r;
  link_event_t       lk_ev_nxt;
  logic              lk_tog_r;
  logic [DATA_W-1:0] lk_out_r;

  // Core side
  logic              ev_pulse;
  link_event_t       ev;
  logic              cmd_take;
  logic              cmd_read;
  logic              mode_take;
  logic              data_read;
  logic              chan_change;
  logic              start_conv;
  logic              pd_enter;
  logic              rdy_n;
  logic              err;
  logic [1:0]        channel_r;
  mode_t             mode_r;
  mode_t             mode_wr_val;
  status_t           status;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] rd_word_r;
  logic [DATA_W-1:0] rd_word_nxt;
  logic [1:0]        cmd_rs;

  // Frame end clears the serial state; clock may stop outside frames
  assign lk_clr      = rst_in | cs_n_in;
  assign lk_byte     = {lk_sh_r[6:0], din_in};
  assign lk_last_idx = (lk_phase_r == PH_READ && lk_rs_r == RS_DATA)
                     ? 5'(DATA_W - 1) : 5'(LAST_BYTE_BIT);
  assign lk_last     = (lk_cnt_r == lk_last_idx);
  // Leading one keeps the port parked at the first command bit
  assign lk_hold     = (lk_phase_r == PH_CMD) && (lk_cnt_r == 5'h00)
                     && din_in;                             // [RULE21]
  assign lk_cmd_done = (lk_phase_r == PH_CMD) && lk_last;
  assign lk_cnt_nxt  = lk_hold ? lk_cnt_r
                     : lk_last ? 5'h00 : 5'(lk_cnt_r + 5'h01);

  always_comb
  begin
    lk_phase_nxt = lk_phase_r;
    case (lk_phase_r)
      PH_CMD:
        if (lk_last)
        begin
          if (lk_byte[CMD_RW_BIT])
            lk_phase_nxt = PH_READ;                         // [RULE21]
          else if (lk_byte[CMD_RS_MSB:CMD_RS_LSB] == RS_MODE)
            lk_phase_nxt = PH_WRITE;                        // [RULE22]
          else
            lk_phase_nxt = PH_CMD;
        end
      PH_WRITE:
        if (lk_last)
          lk_phase_nxt = PH_CMD;
      PH_READ:
        if (lk_last)
          lk_phase_nxt = PH_CMD;
      default:
        lk_phase_nxt = PH_CMD;
    endcase
  end

  always_comb
  begin
    lk_ev_nxt.value = lk_byte;
    lk_ev_nxt.rs    = lk_cmd_done ? lk_byte[CMD_RS_MSB:CMD_RS_LSB] : lk_rs_r;
    case (lk_phase_r)
      PH_CMD:   lk_ev_nxt.kind = EV_CMD;
      PH_WRITE: lk_ev_nxt.kind = EV_MODE;
      PH_READ:  lk_ev_nxt.kind = EV_READ_DONE;
      default:  lk_ev_nxt.kind = EV_CMD;
    endcase
  end

  always_ff @(posedge sclk_in or posedge lk_clr)
  begin
    if (lk_clr)
    begin
      lk_phase_r <= PH_CMD;
      lk_cnt_r   <= 5'h00;
      lk_sh_r    <= 8'h00;
      lk_rs_r    <= RS_COMM_STATUS;
    end
    else
    begin
      lk_phase_r <= lk_phase_nxt;
      lk_cnt_r   <= lk_cnt_nxt;
      lk_sh_r    <= lk_byte;
      if (lk_cmd_done)
        lk_rs_r <= lk_byte[CMD_RS_MSB:CMD_RS_LSB];
    end
  end

  // Event word is held until the next byte, long after the toggle lands
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lk_ev_r  <= '0;
      lk_tog_r <= 1'b0;
    end
    else if (lk_last)
    begin
      lk_ev_r  <= lk_ev_nxt;
      lk_tog_r <= ~lk_tog_r;
    end
  end

  // rd_word_r is frozen by the core well before this falling edge
  always_ff @(negedge sclk_in or posedge lk_clr)
  begin
    if (lk_clr)
      lk_out_r <= '0;
    else if (lk_phase_r == PH_READ)
      lk_out_r <= (lk_cnt_r == 5'h00) ? rd_word_r
                : {lk_out_r[DATA_W-2:0], 1'b0};             // [RULE4] [RULE18]
  end

  assign dout_out      = (lk_phase_r == PH_READ) ? lk_out_r[DATA_W-1]
                       : rdy_n;                             // [RULE8]
  assign dout_oe_n_out = cs_n_in;

  toggle_sync u_ev_sync (
    .clk_in    (core_clk_in),
    .rst_in    (rst_in),
    .toggle_in (lk_tog_r),
    .pulse_out (ev_pulse)
  );

  assign ev          = lk_ev_r;
  assign cmd_rs      = ev.value[CMD_RS_MSB:CMD_RS_LSB];
  assign cmd_take    = ev_pulse && ev.kind == EV_CMD;
  assign cmd_read    = cmd_take && ev.value[CMD_RW_BIT];
  assign mode_take   = ev_pulse && ev.kind == EV_MODE;      // [RULE16]
  assign data_read   = ev_pulse && ev.kind == EV_READ_DONE
                     && ev.rs == RS_DATA;                   // [RULE6]
  assign chan_change = cmd_take
                     && ev.value[CMD_CH_MSB:0] != channel_r; // [RULE23]
  assign start_conv  = mode_take || chan_change;            // [RULE11]
  // Fixed bits are forced so the layout never drifts
  assign mode_wr_val = {ev.value[MR_OP_MSB:MR_OP_LSB], 3'h0,
                        ev.value[MR_UB_BIT], 1'b1, 1'b0};   // [RULE18]
  assign pd_enter    = mode_take
                     && mode_wr_val.operating_select == OP_POWER_DOWN
                     && mode_r.operating_select != OP_POWER_DOWN; // [RULE7]

  // No write path reaches these bits
  assign status = {rdy_n, err, 2'h0, 1'b1, VARIANT_FLAG,
                   channel_r};                   // [RULE2] [RULE12] [RULE13]

  assign rd_word_nxt = (cmd_rs == RS_COMM_STATUS)
                     ? {status, {(DATA_W-8){1'b0}}}         // [RULE3] [RULE22]
                     : (cmd_rs == RS_MODE)
                     ? {mode_r, {(DATA_W-8){1'b0}}}
                     : (cmd_rs == RS_DATA) ? data_r : '0;

  result_flags u_flags (
    .clk_in          (core_clk_in),
    .rst_in          (rst_in),
    .result_write_in (result_valid_in),
    .clamp_in        (clamp_in),
    .data_read_in    (data_read),
    .update_soon_in  (update_soon_in),
    .mode_write_in   (mode_take),
    .pd_enter_in     (pd_enter),
    .start_conv_in   (start_conv),
    .rdy_n_out       (rdy_n),
    .err_out         (err)
  );

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      channel_r <= CH_RESET;                                // [RULE15]
      mode_r    <= MODE_RESET;                              // [RULE17]
    end
    else
    begin
      if (cmd_take)
        channel_r <= ev.value[CMD_CH_MSB:0];                // [RULE1] [RULE14]
      if (mode_take)
        mode_r <= mode_wr_val;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      data_r           <= '0;
      rd_word_r        <= '0;
      filter_reset_out <= 1'b0;
    end
    else
    begin
      if (result_valid_in)
        data_r <= result_in;
      if (cmd_read)
        rd_word_r <= rd_word_nxt;
      filter_reset_out <= start_conv;                       // [RULE20] [RULE23]
    end
  end

  assign input_select_out     = channel_r;
  assign operating_select_out = mode_r.operating_select;
  assign unipolar_out         = mode_r.unipolar;            // [RULE19]
  assign power_down_out       = mode_r.operating_select == OP_POWER_DOWN;

  sequence s_mode_effect;
    rdy_n && filter_reset_out && !err;
  endsequence

  sequence s_msb_first;
    dout_out == rd_word_r[DATA_W-1] ##1 dout_out == rd_word_r[DATA_W-2];
  endsequence

  property p_reset_state;
    @(posedge core_clk_in) disable iff (rst_in)
    $fell(rst_in) |-> status == {RDY_N_RESET, ERR_RESET, 2'h0, 1'b1,
                                 VARIANT_FLAG, CH_RESET}
                      && mode_r == MODE_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) // [RULE15] [RULE17]
    else $error("Reset values of status or mode wrong");

  property p_fixed_bits;
    @(posedge core_clk_in) disable iff (rst_in)
    status[5:3] == 3'h1 && status[2] == VARIANT_FLAG
    && mode_r[5:3] == 3'h0 && mode_r[1:0] == 2'h2;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) // [RULE12] [RULE13]
    else $error("Fixed status or mode bits wrong");

  property p_mode_write;
    @(posedge core_clk_in) disable iff (rst_in)
    mode_take && !result_valid_in |=> s_mode_effect
      ##0 mode_r == {$past(ev.value[7:6]), 3'h0, $past(ev.value[2]), 2'h2};
  endproperty
  a_mode_write: assert property (p_mode_write) // [RULE20] [RULE18]
    else $error("Mode write effects missing");

  property p_result_clears;
    @(posedge core_clk_in) disable iff (rst_in)
    result_valid_in |=> !rdy_n && err == $past(clamp_in)
                        && data_r == $past(result_in);
  endproperty
  a_result_clears: assert property (p_result_clears) // [RULE5] [RULE9] [RULE10]
    else $error("Result did not clear pending or set error");

  property p_read_sets;
    @(posedge core_clk_in) disable iff (rst_in)
    (data_read || update_soon_in) && !result_valid_in |=> rdy_n;
  endproperty
  a_read_sets: assert property (p_read_sets) // [RULE6]
    else $error("Pending not set after read or update notice");

  property p_power_down;
    @(posedge core_clk_in) disable iff (rst_in)
    pd_enter && !result_valid_in |=> rdy_n && power_down_out;
  endproperty
  a_power_down: assert property (p_power_down) // [RULE7] [RULE19]
    else $error("Power-down entry did not set pending");

  property p_err_clear;
    @(posedge core_clk_in) disable iff (rst_in)
    chan_change && !result_valid_in |=> !err && filter_reset_out
                                        ##1 !filter_reset_out;
  endproperty
  a_err_clear: assert property (p_err_clear) // [RULE11] [RULE23]
    else $error("Channel change did not restart conversion");

  property p_channel;
    @(posedge core_clk_in) disable iff (rst_in)
    cmd_take |=> status[1:0] == $past(ev.value[1:0]);
  endproperty
  a_channel: assert property (p_channel) // [RULE14] [RULE1]
    else $error("Status channel bits not updated");

  property p_read_status;
    @(posedge core_clk_in) disable iff (rst_in)
    cmd_read && cmd_rs == RS_COMM_STATUS |=>
      rd_word_r[DATA_W-1 -: 8] == $past(status);
  endproperty
  a_read_status: assert property (p_read_status) // [RULE22] [RULE2]
    else $error("Status snapshot wrong");

  property p_msb_first;
    @(posedge sclk_in) disable iff (lk_clr)
    lk_phase_r == PH_READ && lk_cnt_r == 5'h00 |-> s_msb_first;
  endproperty
  a_msb_first: assert property (p_msb_first) // [RULE4]
    else $error("Read data not shifted MSB first");

  property p_start_bit;
    @(posedge sclk_in) disable iff (lk_clr)
    lk_phase_r == PH_CMD && lk_cnt_r == 5'h00 && din_in |=>
      lk_cnt_r == 5'h00;
  endproperty
  a_start_bit: assert property (p_start_bit) // [RULE21]
    else $error("Command accepted a leading one");
endmodule
`default_nettype wire

// ---- host_link_model.sv ----
// Purpose: Host side of the converter serial port, clocking whole frames
// Assumes: sclk idles high and stands still between frames
// Notes:   Half periods 63/62 ns give the 125 ns link clock
`timescale 1ns/1ns
`default_nettype none
module host_link_model
  import adc_regs_pkg::*;
(
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in
);
  initial
  begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end

  // Data set on the falling edge, device samples on the rising edge
  task automatic put_bit(input logic d, output logic q);
    sclk_out = 1'b0;
    din_out  = d;
    #63;
    // Sampled just before the rising edge that may end the read phase
    q = dout_in;
    sclk_out = 1'b1;
    #62;
  endtask

  task automatic frame(input int lead, input logic [7:0] cmd,
                       input logic [7:0] wbyte, input int nrd,
                       input bit slow, output logic [23:0] rd);
    logic q;
    rd = '0;
    cs_n_out = 1'b0;
    #40;
    for (int i = 0; i < lead; i++)
      put_bit(1'b1, q);
    for (int i = 7; i >= 0; i--)
      put_bit(cmd[i], q);
    // Slow host pauses with the clock parked high
    if (slow)
      #300;
    if (!cmd[CMD_RW_BIT] && cmd[5:4] == RS_MODE)
      for (int i = 7; i >= 0; i--)
        put_bit(wbyte[i], q);
    for (int i = 0; i < nrd; i++)
    begin
      put_bit(1'b0, q);
      rd = {rd[22:0], q};
    end
    #40;
    cs_n_out = 1'b1;
    // Released line shows the inverse, never a stale value
    din_out = ~din_out;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the status and mode register block
// Assumes: Host model drives the link; bench drives the filter side
// Notes:   Core events land a few cycles after a frame, so checks settle
`timescale 1ns/1ns
`default_nettype none
module tb
  import adc_regs_pkg::*;
;
  localparam int   DW  = 16;
  localparam logic VAR = 1'b0;
  logic            core_clk_in;
  logic            rst_in;
  logic            sclk;
  logic            cs_n;
  logic            din;
  logic            dout;
  logic            dout_oe_n;
  logic            result_valid;
  logic [DW-1:0]   result;
  logic            clamp;
  logic            update_soon;
  logic            filter_reset;
  logic [1:0]      input_select;
  logic [1:0]      operating_select;
  logic            unipolar;
  logic            power_down;
  logic [1:0]      ch;
  logic [23:0]     rd;
  int              n_mismatch;
  int              comparisons;
  int              n_freset;
  int              f0;

  host_link_model host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
                        .dout_in(dout));

  adc_status_mode_regs #(.DATA_W(DW), .VARIANT_FLAG(VAR)) DUT (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout),
    .dout_oe_n_out(dout_oe_n), .result_valid_in(result_valid),
    .result_in(result), .clamp_in(clamp), .update_soon_in(update_soon),
    .filter_reset_out(filter_reset), .input_select_out(input_select),
    .operating_select_out(operating_select), .unipolar_out(unipolar),
    .power_down_out(power_down));

  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  initial
    n_freset = 0;
  always @(posedge core_clk_in)
    if (filter_reset === 1'b1)
      n_freset <= n_freset + 1;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Mismatches %0d of %0d compares", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [23:0] st(input logic r, input logic e,
                                     input logic [1:0] c);
    return {16'h0000, r, e, 2'b00, 1'b1, VAR, c};
  endfunction

  function automatic logic [7:0] mk(input logic [1:0] rs, input logic rw);
    return {2'b00, rs, rw, 1'b0, ch};
  endfunction

  task automatic settle();
    repeat (6) @(posedge core_clk_in);
  endtask

  task automatic xfer(input logic [1:0] rs, input logic rw,
                      input logic [7:0] wb, input int nrd);
    host.frame(0, mk(rs, rw), wb, nrd, 1'b0, rd);
    settle();
  endtask

  task automatic pulse(input logic c, input logic [DW-1:0] v);
    @(posedge core_clk_in);
    result_valid <= 1'b1;
    clamp        <= c;
    result       <= v;
    @(posedge core_clk_in);
    result_valid <= 1'b0;
    clamp        <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask

  // A hung link is cut short and counted
  initial
  begin
    #900000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    conclude();
  end

  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    ch = CH_DIFF;
    rst_in = 1'b1;
    result_valid = 1'b0;
    result = '0;
    clamp = 1'b0;
    update_soon = 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    check(24'(dout), 24'h1);
    check(24'(dout_oe_n), 24'h1);
    check(24'({operating_select, unipolar, power_down, input_select}),
          24'h0);
    xfer(RS_COMM_STATUS, 1'b1, 8'h00, 8);
    check(rd, st(1'b1, 1'b0, 2'b00));
    xfer(RS_MODE, 1'b1, 8'h00, 8);
    check(rd, 24'h02);
    pulse(1'b1, 16'hA5C3);
    check(24'(dout), 24'h0);
    xfer(RS_COMM_STATUS, 1'b1, 8'h00, 8);
    check(rd, st(1'b0, 1'b1, ch));
    // Stray leading ones must not shift the command
    host.frame(2, mk(RS_DATA, 1'b1), 8'h00, DW, 1'b0, rd);
    settle();
    check(rd, 24'hA5C3);
    xfer(RS_COMM_STATUS, 1'b1, 8'h00, 8);
    check(24'(rd[7]), 24'h1);
    pulse(1'b0, 16'h0001);
    @(posedge core_clk_in);
    update_soon <= 1'b1;
    @(posedge core_clk_in);
    update_soon <= 1'b0;
    settle();
    check(24'(dout), 24'h1);
    pulse(1'b1, 16'hFFFF);
    f0 = n_freset;
    xfer(RS_MODE, 1'b0, 8'h04, 0);
    check(24'(n_freset - f0), 24'h1);
    check(24'({operating_select, unipolar, power_down}), 24'h2);
    xfer(RS_COMM_STATUS, 1'b1, 8'h00, 8);
    check(rd, st(1'b1, 1'b0, ch));
    xfer(RS_MODE, 1'b1, 8'h00, 8);
    check(rd, 24'h06);
    pulse(1'b0, 16'h1234);
    xfer(RS_MODE, 1'b0, 8'hFF, 0);
    check(24'({operating_select, power_down}), 24'h7);
    check(24'(dout), 24'h1);
    host.frame(0, mk(RS_MODE, 1'b1), 8'h00, 8, 1'b1, rd);
    settle();
    check(rd, 24'hC6);
    xfer(RS_RESERVED, 1'b1, 8'h00, 8);
    check(rd, 24'h0);
    // Reserved channel code is never programmed
    for (int k = 0; k < 3; k++)
    begin
      f0 = n_freset;
      ch = (k == 0) ? CH_SHORTED : (k == 1) ? CH_SUPPLY : CH_DIFF;
      xfer(RS_COMM_STATUS, 1'b0, 8'h00, 0);
      check(24'(input_select), 24'(ch));
      check(24'(n_freset - f0), 24'h1);
      xfer(RS_COMM_STATUS, 1'b1, 8'h00, 8);
      check(rd, st(1'b1, 1'b0, ch));
    end
    f0 = n_freset;
    xfer(RS_COMM_STATUS, 1'b1, 8'h00, 8);
    check(24'(n_freset - f0), 24'h0);
    conclude();
  end
endmodule
`default_nettype wire
